// ==== shared/gpd_cfg.svh ====
// Constants for the general-purpose pin data port: offsets, reset values, serial framing.
// Assumes inclusion by bare name from the package and the design modules.
// Functional notes
// - Eight-bit pin data register, bit n belongs to pin n, pins shared with analog.
// - Data bit zero means low, one means high; all bits reset to zero.
// - Output pin reads back stored value; stored value drives the pin.
// - Input pin write only updates stored value, never drives the pin.
// - Direction bit zero selects output (reset default), one selects input.
// - Enable bit one connects the pin function; zero (default) leaves analog input.
// - Serial port uses SPI mode 1, clock polarity zero, phase one.
// - Serial clock idles low; outgoing bits change only on rising edges.
// - Incoming serial bits are captured on falling serial clock edges.
`ifndef GPD_CFG_SVH
`define GPD_CFG_SVH
`define GPD_WIDTH 8
`define GPD_OFS_ENABLE 4'hC
`define GPD_OFS_DIR 4'hD
`define GPD_OFS_LEVEL 4'hE
`define GPD_RST_ENABLE 8'h00
`define GPD_RST_DIR 8'h00
`define GPD_RST_LEVEL 8'h00
`define GPD_CMD_WRITE 4'h4
`define GPD_CMD_READ 4'h2
`define GPD_FRAME_BITS 5'h10
`endif

// ==== shared/gpd_pkg.sv ====
// Types for the general-purpose pin data port.
// Assumes the constants header sits beside it.
`include "gpd_cfg.svh"
package gpd_pkg;
   typedef logic [7:0] gpd_byte_t;
   typedef enum logic [1:0] {GPD_IDLE, GPD_BUSY, GPD_DONE} gpd_link_t;
endpackage

// ==== rtl/gpd_spi_link.sv ====
// Serial link end on the serial clock: two-byte frames, command byte then data byte.
// Assumes chip select low frames a transfer and the serial clock rests low between frames.
`timescale 1ns/1ps
`include "gpd_cfg.svh"
module gpd_spi_link
   import gpd_pkg::*;
(
   input wire logic sclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   input wire logic [7:0] rd_data,
   output logic [7:0] cmd_byte,
   output logic [7:0] wr_byte,
   output logic frame_tgl,
   output logic cmd_tgl
);
   logic [4:0] cnt_q;
   logic [15:0] shf_q;
   logic [7:0] tx_q;
   logic frame_q;
   logic cmd_q;
   wire [15:0] shf_d = {shf_q[14:0], mosi};

   // Capture on falling edges; counter restarts whenever chip select is high.
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_q <= 5'h00;
         shf_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 5'h01;
         shf_q <= shf_d;
      end
   end

   // Frame results are published by toggles, crossed by the core.
   // The toggles start from a known level, or the core would never see an edge.
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_byte <= 8'h00;
         wr_byte <= 8'h00;
         cmd_q <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         if (!cs_n && cnt_q == 5'h07) begin
            cmd_byte <= shf_d[7:0];
            cmd_q <= ~cmd_q;
         end
         if (!cs_n && cnt_q == `GPD_FRAME_BITS - 5'h01) begin
            wr_byte <= shf_d[7:0];
            frame_q <= ~frame_q;
         end
      end
   end

   // Launch on rising edges only; the read byte shifts out in the second byte.
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         miso <= 1'b0;
         tx_q <= 8'h00;
      end else if (cnt_q == 5'h08) begin
         miso <= rd_data[7];
         tx_q <= {rd_data[6:0], 1'b0};
      end else begin
         miso <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   assign frame_tgl = frame_q;
   assign cmd_tgl = cmd_q;
endmodule

// ==== rtl/gpd_pin_port.sv ====
// Pin data port core: enable, direction and level registers behind a mode-1 serial port.
// Assumes clk at 200 MHz, serial clock from the host, pins resolved by the bench.
// Reset reaches the serial end as well, so its toggles start level with the core.
`timescale 1ns/1ps
`include "gpd_cfg.svh"
module gpd_pin_port
   import gpd_pkg::*;
#(
   parameter int WIDTH = `GPD_WIDTH
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pin_function_enable_bits
);
   logic rst_a_q, rst_n_q;
   logic [WIDTH-1:0] pin_level_bits_q, pin_direction_bits_q, fn_en_q;
   logic [WIDTH-1:0] pin_s1_q, pin_s2_q;
   logic [WIDTH-1:0] out_q, oe_q;
   logic [2:0] fr_s_q, cm_s_q;
   logic [7:0] rd_q;
   logic [7:0] cmd_byte, wr_byte, cmd_cap_q;
   logic frame_tgl, cmd_tgl;
   logic cm_ev_q;
   gpd_link_t frame_state_q, frame_state_d;

   // Reset release through two flip-flops.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_a_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n_q <= rst_a_q;
      end
   end

   // Serial end of the link; it runs on the serial clock and shares the core's reset.
   gpd_spi_link u_link (
      .sclk(sclk),
      .rst_n(rst_n_q),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .rd_data(rd_q),
      .cmd_byte(cmd_byte),
      .wr_byte(wr_byte),
      .frame_tgl(frame_tgl),
      .cmd_tgl(cmd_tgl)
   );

   // Toggle crossings and pin synchronisers; first stage feeds only the second.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fr_s_q <= 3'h0;
         cm_s_q <= 3'h0;
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         fr_s_q <= {fr_s_q[1:0], frame_tgl};
         cm_s_q <= {cm_s_q[1:0], cmd_tgl};
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   wire fr_ev = fr_s_q[2] ^ fr_s_q[1];
   wire cm_ev = cm_s_q[2] ^ cm_s_q[1];
   wire is_wr = cmd_cap_q[7:4] == `GPD_CMD_WRITE;
   wire is_rd = cmd_cap_q[7:4] == `GPD_CMD_READ;
   wire [3:0] addr = cmd_cap_q[3:0];

   // Address match, shared by the read selector and the write strobes.
   function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] ofs);
      return a == ofs;
   endfunction

   // Register selects; an unknown address selects nothing.
   wire hit_level = reg_hit(addr, `GPD_OFS_LEVEL);
   wire hit_dir = reg_hit(addr, `GPD_OFS_DIR);
   wire hit_en = reg_hit(addr, `GPD_OFS_ENABLE);

   // Output pins read the stored value, input pins the synchronised level.
   wire [WIDTH-1:0] level_view = (pin_level_bits_q & ~pin_direction_bits_q)
      | (pin_s2_q & pin_direction_bits_q);
   wire [7:0] rd_sel = hit_level ? 8'(level_view) :
      hit_dir ? 8'(pin_direction_bits_q) :
      hit_en ? 8'(fn_en_q) : 8'h00;

   // Frame tracker: a crossed command byte opens a frame, the frame toggle closes it.
   always_comb begin
      frame_state_d = frame_state_q;
      case (frame_state_q)
         GPD_IDLE: begin
            if (cm_ev) frame_state_d = GPD_BUSY;
         end
         GPD_BUSY: begin
            if (fr_ev) frame_state_d = GPD_DONE;
         end
         GPD_DONE: begin
            frame_state_d = cm_ev ? GPD_BUSY : GPD_IDLE;
         end
         default: begin
            frame_state_d = GPD_IDLE;
         end
      endcase
   end

   // A frame cut short leaves the tracker busy until the next frame toggle closes it.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         frame_state_q <= GPD_IDLE;
      end else begin
         frame_state_q <= frame_state_d;
      end
   end

   // Write strobes: only a complete frame that carried a write command lands.
   wire wr_ok = fr_ev && is_wr && (frame_state_q == GPD_BUSY);
   wire wr_level = wr_ok && hit_level;
   wire wr_dir = wr_ok && hit_dir;
   wire wr_en = wr_ok && hit_en;

   // Command byte is latched as it crosses; read data is taken once, a cycle later,
   // so the word stands still while the link shifts it out.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cmd_cap_q <= 8'h00;
         cm_ev_q <= 1'b0;
         rd_q <= 8'h00;
      end else begin
         cm_ev_q <= cm_ev;
         if (cm_ev) cmd_cap_q <= cmd_byte;
         if (cm_ev_q && is_rd) rd_q <= rd_sel;
      end
   end

   // Register writes; a level write only stores, whatever the direction.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_level_bits_q <= `GPD_RST_LEVEL;
         pin_direction_bits_q <= `GPD_RST_DIR;
         fn_en_q <= `GPD_RST_ENABLE;
      end else begin
         if (wr_level) pin_level_bits_q <= wr_byte[WIDTH-1:0];
         if (wr_dir) pin_direction_bits_q <= wr_byte[WIDTH-1:0];
         if (wr_en) fn_en_q <= wr_byte[WIDTH-1:0];
      end
   end

   // Drive only enabled output pins, with the stored level.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         out_q <= '0;
         oe_q <= '0;
      end else begin
         out_q <= pin_level_bits_q;
         oe_q <= fn_en_q & ~pin_direction_bits_q;
      end
   end

   // Top-level outputs come straight from their registers.
   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign pin_function_enable_bits = fn_en_q;

   // Pin drive checks, bit by bit and on whole words.
   a_out_drive: assert property (@(posedge clk) disable iff (!rst_n_q)
      pin_oe[0] |-> pin_out[0] == $past(pin_level_bits_q[0])) else $error("pin out level wrong");
   a_in_nodrive: assert property (@(posedge clk) disable iff (!rst_n_q)
      $past(pin_direction_bits_q[0]) |-> !pin_oe[0]) else $error("input pin driven");
   a_en_gate: assert property (@(posedge clk) disable iff (!rst_n_q)
      $past(!fn_en_q[1]) |-> !pin_oe[1]) else $error("disabled pin driven");
   a_out_follow: assert property (@(posedge clk) disable iff (!rst_n_q)
      pin_out == $past(pin_level_bits_q))
      else $error("pin out does not follow stored level");
   a_oe_value: assert property (@(posedge clk) disable iff (!rst_n_q)
      pin_oe == $past(fn_en_q & ~pin_direction_bits_q))
      else $error("pin drive enable wrong");

   // Register write, read, frame and reset checks.
   a_level_store: assert property (@(posedge clk) disable iff (!rst_n_q)
      wr_level |=> pin_level_bits_q == $past(wr_byte[WIDTH-1:0]))
      else $error("level write lost");
   a_dir_store: assert property (@(posedge clk) disable iff (!rst_n_q)
      wr_dir |=> pin_direction_bits_q == $past(wr_byte[WIDTH-1:0]))
      else $error("direction write lost");
   a_en_store: assert property (@(posedge clk) disable iff (!rst_n_q)
      wr_en |=> fn_en_q == $past(wr_byte[WIDTH-1:0]))
      else $error("enable write lost");
   a_stray_write: assert property (@(posedge clk) disable iff (!rst_n_q)
      fr_ev && !wr_ok |=> $stable(pin_level_bits_q))
      else $error("level changed by a frame that was no write");
   a_read_pick: assert property (@(posedge clk) disable iff (!rst_n_q)
      cm_ev_q && is_rd |=> rd_q == $past(rd_sel))
      else $error("read word not taken");
   a_rd_refuse: assert property (@(posedge clk) disable iff (!rst_n_q)
      cm_ev_q && is_rd && !(hit_level || hit_dir || hit_en) |=> rd_q == 8'h00)
      else $error("unknown address read not zero");
   a_frame_close: assert property (@(posedge clk) disable iff (!rst_n_q)
      fr_ev && frame_state_q == GPD_BUSY |=> frame_state_q == GPD_DONE)
      else $error("frame end not seen");
   a_reset_clear: assert property (@(posedge clk) !rst_n_q |->
      pin_level_bits_q == `GPD_RST_LEVEL && pin_direction_bits_q == `GPD_RST_DIR
      && fn_en_q == `GPD_RST_ENABLE)
      else $error("registers not cleared by reset");

   // Main scenarios: a write, a read, a driven high pin, an input read, a closed frame.
   c_write: cover property (@(posedge clk) fr_ev && is_wr);
   c_read: cover property (@(posedge clk) cm_ev ##1 is_rd);
   c_drive: cover property (@(posedge clk) pin_oe[0] && pin_out[0]);
   c_input_read: cover property (@(posedge clk) cm_ev_q && is_rd && hit_level && (|pin_direction_bits_q));
   c_frame_done: cover property (@(posedge clk) frame_state_q == GPD_DONE);
endmodule

// ==== testbench/gpd_host_model.sv ====
// Host model: sends two-byte mode-1 serial frames and collects the reply byte.
// Assumes the device samples on falling edges and answers on rising ones.
`timescale 1ns/1ps
module gpd_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // Clock rests low and select stays high outside frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // One frame, most significant bit first, with a gap between the two bytes.
   task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
      cs_n = 1'b0;
      #20;
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b1;
         mosi = tx[i];
         #16 sclk = 1'b0;
         if (i < 8) rx[i] = miso;
         #16;
         if (i == 8) #48;
      end
      #20 cs_n = 1'b1;
      mosi = ~mosi;
   endtask
endmodule

// ==== testbench/gpd_pin_port_test.sv ====
// Testbench for the pin data port with a host model on the serial side.
// Assumes undriven pins follow the level the bench puts on them.
`timescale 1ns/1ps
`include "gpd_cfg.svh"
module gpd_pin_port_test
   import gpd_pkg::*;
;
   logic clk, arst_n, sclk, cs_n, mosi, miso;
   gpd_byte_t pin_in, pin_out, pin_oe, fen, ext, r;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   // Driven pins show the device level, the others the outside level.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
   gpd_pin_port u_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso(miso), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_function_enable_bits(fen));
   gpd_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   // Core clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Cycle ceiling that cuts a hang short.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         final_report;
      end
   end
   task automatic check(input string what, input gpd_byte_t exp, input gpd_byte_t got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input gpd_byte_t d);
      gpd_byte_t x;
      u_host.xfer({`GPD_CMD_WRITE, a, d}, x);
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output gpd_byte_t d);
      u_host.xfer({`GPD_CMD_READ, a, 8'h00}, d);
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      rd(`GPD_OFS_LEVEL, r);
      check("level", 8'h00, r);
      rd(`GPD_OFS_DIR, r);
      check("dir", 8'h00, r);
      rd(`GPD_OFS_ENABLE, r);
      check("enable", 8'h00, r);
      check("oe", 8'h00, pin_oe);
      $display("test reset done");
   endtask
   task automatic t_output;
      wr(`GPD_OFS_ENABLE, 8'hFF);
      wr(`GPD_OFS_DIR, 8'h0F);
      ext = 8'h3C;
      wr(`GPD_OFS_LEVEL, 8'hA5);
      check("oe", 8'hF0, pin_oe);
      check("out", 8'hA0, pin_out & 8'hF0);
      check("fen", 8'hFF, fen);
      rd(`GPD_OFS_LEVEL, r);
      check("level", 8'hAC, r);
      $display("test output done");
   endtask
   task automatic t_input;
      wr(`GPD_OFS_LEVEL, 8'h5A);
      check("oe", 8'hF0, pin_oe);
      rd(`GPD_OFS_LEVEL, r);
      check("level", 8'h5C, r);
      wr(`GPD_OFS_DIR, 8'h00);
      check("out", 8'h5A, pin_out);
      rd(`GPD_OFS_LEVEL, r);
      check("level", 8'h5A, r);
      wr(`GPD_OFS_ENABLE, 8'h0F);
      check("oe", 8'h0F, pin_oe);
      rd(4'h3, r);
      check("unmapped", 8'h00, r);
      $display("test input done");
   endtask
   task automatic t_midreset;
      arst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check("oe", 8'h00, pin_oe);
      check("out", 8'h00, pin_out);
      check("fen", 8'h00, fen);
      rd(`GPD_OFS_LEVEL, r);
      check("level", 8'h00, r);
      $display("test midreset done");
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Reset for 20 cycles, then the scenarios in turn.
   initial begin
      arst_n = 1'b0;
      ext = 8'h00;
      repeat (20) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (5) @(posedge clk);
      t_reset;
      t_output;
      t_input;
      t_midreset;
      final_report;
   end
endmodule
